/* File: hw/ltpm_map.svh */
// register addresses, field positions, reset values and latencies of the level monitor
`ifndef LTPM_MAP_SVH
`define LTPM_MAP_SVH

// register addresses (byte wide)
`define LTPM_ADDR_FD_MODE     13'h104
`define LTPM_ADDR_COARSE      13'h105
`define LTPM_ADDR_FINE_HI_L   13'h106
`define LTPM_ADDR_FINE_HI_H   13'h107
`define LTPM_ADDR_FINE_LO_L   13'h108
`define LTPM_ADDR_FINE_LO_H   13'h109
`define LTPM_ADDR_DWELL_L     13'h10a
`define LTPM_ADDR_DWELL_H     13'h10b
`define LTPM_ADDR_PORT_CTRL   13'h111
`define LTPM_ADDR_MON_CTRL    13'h112
`define LTPM_ADDR_PERIOD_0    13'h113
`define LTPM_ADDR_PERIOD_1    13'h114
`define LTPM_ADDR_PERIOD_2    13'h115
`define LTPM_ADDR_RESULT_A0   13'h116
`define LTPM_ADDR_RESULT_B0   13'h119

// field positions
`define LTPM_FD_EN_BIT        0
`define LTPM_FD_MODE_LSB      1
`define LTPM_FD_MODE_MSB      3
`define LTPM_MON_EN_BIT       0
`define LTPM_MON_MODE_LSB     1
`define LTPM_MON_MODE_MSB     2
`define LTPM_PORT_PEAK_BIT    0
`define LTPM_PORT_RMS_BIT     1
`define LTPM_PORT_THR_BIT     2

// field codes
`define LTPM_MON_MODE_PEAK    2'h1

// reset values
`define LTPM_RST_DWELL        16'h0001
`define LTPM_RST_PERIOD       24'h000080

// latencies in converter clocks
`define LTPM_OVR_LAT          12
`define LTPM_FM_SLOW_LAT      6

`endif

/* File: hw/ltpm_pkg.sv */
// types shared by the level threshold and peak monitor
package ltpm_pkg;

  // fast indicator routing codes
  typedef enum logic [2:0] {
    LTPM_FD_FM4     = 3'h0,
    LTPM_FD_FM3_OR  = 3'h1,
    LTPM_FD_FM2_OR  = 3'h2,
    LTPM_FD_FM2_CUT = 3'h3,
    LTPM_FD_FLAGS   = 3'h4,
    LTPM_FD_GAIN    = 3'h5,
    LTPM_FD_RSV6    = 3'h6,
    LTPM_FD_RSV7    = 3'h7
  } ltpm_fd_mode_t;

  // one converter channel as it arrives each sample clock
  typedef struct packed {
    logic [11:0] sample;    // signed pipeline output
    logic [2:0]  fast_mag;  // early-stage coarse magnitude
    logic        ovr;       // overrange seen at the input
  } ltpm_chan_in_t;

  // per-channel level flags, stretched
  typedef struct packed {
    logic ovr;
    logic coarse_high_flag;
    logic fine_high_flag;
    logic fine_low_flag;
    logic gain_raise_flag;
    logic gain_lower_flag;
  } ltpm_flags_t;

endpackage

/* File: hw/ltpm_peak.sv */
// peak detector over a programmable measurement period for one channel
`timescale 1ns/1ps
`default_nettype none

module ltpm_peak
  import ltpm_pkg::*;
#(
  parameter int MAG_W = 13,
  parameter int PER_W = 24,
  parameter int RES_W = 20
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // control
  input  wire logic             active,
  input  wire logic [PER_W-1:0] period,
  // sample magnitude
  input  wire logic [MAG_W-1:0] mag,
  // result
  output logic      [RES_W-1:0] result_q
);

  logic             active_q;
  logic             first_q;
  logic [PER_W-1:0] count_q;
  logic [MAG_W-1:0] peak_q;
  logic [MAG_W-1:0] peak_d;

  // first sample of a period seeds the peak, later ones keep the larger
  always_comb begin
    if (first_q || !active_q) begin
      peak_d = mag;
    end else begin
      peak_d = (mag > peak_q) ? mag : peak_q;
    end
  end

  // period down-counter, loaded at enable and at each count of one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= 1'b0;
      first_q  <= 1'b1;
      count_q  <= '0;
      peak_q   <= '0;
    end else begin
      active_q <= active;
      peak_q   <= peak_d;
      if (!active) begin
        first_q <= 1'b1;
      end else if (!active_q) begin
        count_q <= period;
        first_q <= 1'b0;
      end else if (count_q == PER_W'(1)) begin
        count_q <= period;
        first_q <= 1'b1;
      end else begin
        count_q <= count_q - PER_W'(1);
        first_q <= 1'b0;
      end
    end
  end

  // hand the finished peak to the result register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_q <= '0;
    end else if (active && active_q && count_q == PER_W'(1)) begin
      result_q <= RES_W'(peak_d);
    end
  end

endmodule

`default_nettype wire

/* File: hw/ltpm_monitor.sv */
// level threshold flags, fast indicator pins, gain steps and peak monitor for two channels
//
// Summary of operation
// - overrange flag appears exactly 12 converter clocks after the input overrange
// - coarse high flag set when fast magnitude exceeds the 3-bit coarse level
// - coarse high flag appears two clocks after the level is exceeded
// - coarse high flag holds at least two clocks, then while above level
// - coarse codes 000..111 select rising trip levels from -24 to -1.8 dBFS; here code 111 never trips, as the 3-bit fast magnitude cannot exceed 7
// - fine high flag set when output magnitude exceeds 13-bit fine high level
// - fine low flag set when output magnitude is below 13-bit fine low level
// - gain lower flag follows the coarse high comparison on the fast path
// - gain raise flag only after magnitude stays below fine low for dwell time
// - dwell time is a 16-bit clock count over two bytes, 1 to 65535
// - indicators other than gain raise follow instantaneous level; all flags stay on at least 2 clocks
// - each channel has its own 20-bit result, readable at 0x116 to 0x11B
// - serial monitor port has separate enables for peak, rms and crossing results
// - measurement period is a 24-bit count in three bytes from 0x113
// - peak mode active on mode code 1 or when the peak port enable is set, only while the monitor enable is set
// - enabling peak mode loads the period counter and starts counting at once
// - peak starts at current magnitude, then keeps the larger each sample
// - at count one the peak goes to the result and the counter reloads
// - result holds the largest magnitude of the last completed period
// - fast indicator mode routes flags onto the four pins per code
// - fast indicator codes 001 to 011 give the fast magnitude pins six clocks latency
`timescale 1ns/1ps
`default_nettype none
`include "ltpm_map.svh"

module ltpm_monitor
  import ltpm_pkg::*;
#(
  parameter int NCH   = 2,
  parameter int MAG_W = 13,
  parameter int PER_W = 24,
  parameter int RES_W = 20,
  parameter int DWL_W = 16
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // converter channels
  input  wire ltpm_chan_in_t        chan_in [NCH],
  // register access, byte wide
  input  wire logic [12:0]          reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata_q,
  output logic                      reg_rvalid_q,
  // indicator pins
  output logic      [NCH-1:0][3:0]  fast_indicator_pins,
  // serial monitor port result enables
  output logic                      port_peak_en_q,
  output logic                      port_rms_en_q,
  output logic                      port_thr_en_q
);

  // ==========================================================
  // registers
  // ==========================================================
  logic [7:0]       fd_ctrl_q;
  logic [2:0]       coarse_trip_level_q;
  logic [MAG_W-1:0] fine_high_trip_level_q;
  logic [MAG_W-1:0] fine_low_trip_level_q;
  logic [DWL_W-1:0] gain_raise_dwell_count_q;
  logic [2:0]       port_ctrl_q;
  logic [2:0]       mon_ctrl_q;
  logic [PER_W-1:0] measure_period_length_q;
  logic [RES_W-1:0] measure_result_value [NCH];

  ltpm_fd_mode_t fd_mode;
  logic          fd_enable;
  logic          peak_active;

  assign fd_mode   = ltpm_fd_mode_t'(fd_ctrl_q[`LTPM_FD_MODE_MSB:`LTPM_FD_MODE_LSB]);
  assign fd_enable = fd_ctrl_q[`LTPM_FD_EN_BIT];

  // peak mode on mode code or port enable, gated by monitor enable
  assign peak_active = mon_ctrl_q[`LTPM_MON_EN_BIT] &&
    ((mon_ctrl_q[`LTPM_MON_MODE_MSB:`LTPM_MON_MODE_LSB] == `LTPM_MON_MODE_PEAK) ||
     port_ctrl_q[`LTPM_PORT_PEAK_BIT]);

  // write decode of the control registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fd_ctrl_q                <= 8'h00;
      coarse_trip_level_q      <= 3'h0;
      fine_high_trip_level_q   <= '0;
      fine_low_trip_level_q    <= '0;
      gain_raise_dwell_count_q <= `LTPM_RST_DWELL;
      port_ctrl_q              <= 3'h0;
      mon_ctrl_q               <= 3'h0;
      measure_period_length_q  <= `LTPM_RST_PERIOD;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `LTPM_ADDR_FD_MODE:   fd_ctrl_q <= {4'h0, reg_wdata[3:0]};
        `LTPM_ADDR_COARSE:    coarse_trip_level_q <= reg_wdata[2:0];
        `LTPM_ADDR_FINE_HI_L: fine_high_trip_level_q[7:0] <= reg_wdata;
        `LTPM_ADDR_FINE_HI_H: fine_high_trip_level_q[MAG_W-1:8] <= reg_wdata[MAG_W-9:0];
        `LTPM_ADDR_FINE_LO_L: fine_low_trip_level_q[7:0] <= reg_wdata;
        `LTPM_ADDR_FINE_LO_H: fine_low_trip_level_q[MAG_W-1:8] <= reg_wdata[MAG_W-9:0];
        `LTPM_ADDR_DWELL_L:   gain_raise_dwell_count_q[7:0] <= reg_wdata;
        `LTPM_ADDR_DWELL_H:   gain_raise_dwell_count_q[15:8] <= reg_wdata;
        `LTPM_ADDR_PORT_CTRL: port_ctrl_q <= reg_wdata[2:0];
        `LTPM_ADDR_MON_CTRL:  mon_ctrl_q <= reg_wdata[2:0];
        `LTPM_ADDR_PERIOD_0:  measure_period_length_q[7:0] <= reg_wdata;
        `LTPM_ADDR_PERIOD_1:  measure_period_length_q[15:8] <= reg_wdata;
        `LTPM_ADDR_PERIOD_2:  measure_period_length_q[23:16] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // byte select of a 20-bit result
  function automatic logic [7:0] res_byte(input logic [RES_W-1:0] r, input logic [1:0] k);
    logic [23:0] w;
    w = {4'h0, r};
    return w[k*8 +: 8];
  endfunction

  // read mux, answer one clock after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          `LTPM_ADDR_FD_MODE:   reg_rdata_q <= fd_ctrl_q;
          `LTPM_ADDR_COARSE:    reg_rdata_q <= {5'h00, coarse_trip_level_q};
          `LTPM_ADDR_FINE_HI_L: reg_rdata_q <= fine_high_trip_level_q[7:0];
          `LTPM_ADDR_FINE_HI_H: reg_rdata_q <= {3'h0, fine_high_trip_level_q[MAG_W-1:8]};
          `LTPM_ADDR_FINE_LO_L: reg_rdata_q <= fine_low_trip_level_q[7:0];
          `LTPM_ADDR_FINE_LO_H: reg_rdata_q <= {3'h0, fine_low_trip_level_q[MAG_W-1:8]};
          `LTPM_ADDR_DWELL_L:   reg_rdata_q <= gain_raise_dwell_count_q[7:0];
          `LTPM_ADDR_DWELL_H:   reg_rdata_q <= gain_raise_dwell_count_q[15:8];
          `LTPM_ADDR_PORT_CTRL: reg_rdata_q <= {5'h00, port_ctrl_q};
          `LTPM_ADDR_MON_CTRL:  reg_rdata_q <= {5'h00, mon_ctrl_q};
          `LTPM_ADDR_PERIOD_0:  reg_rdata_q <= measure_period_length_q[7:0];
          `LTPM_ADDR_PERIOD_1:  reg_rdata_q <= measure_period_length_q[15:8];
          `LTPM_ADDR_PERIOD_2:  reg_rdata_q <= measure_period_length_q[23:16];
          `LTPM_ADDR_RESULT_A0:         reg_rdata_q <= res_byte(measure_result_value[0], 2'd0);
          `LTPM_ADDR_RESULT_A0 + 13'h1: reg_rdata_q <= res_byte(measure_result_value[0], 2'd1);
          `LTPM_ADDR_RESULT_A0 + 13'h2: reg_rdata_q <= res_byte(measure_result_value[0], 2'd2);
          `LTPM_ADDR_RESULT_B0:         reg_rdata_q <= res_byte(measure_result_value[1], 2'd0);
          `LTPM_ADDR_RESULT_B0 + 13'h1: reg_rdata_q <= res_byte(measure_result_value[1], 2'd1);
          `LTPM_ADDR_RESULT_B0 + 13'h2: reg_rdata_q <= res_byte(measure_result_value[1], 2'd2);
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // serial monitor port enables mirror the port control bits, gated by the monitor enable
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      port_peak_en_q <= 1'b0;
      port_rms_en_q  <= 1'b0;
      port_thr_en_q  <= 1'b0;
    end else begin
      port_peak_en_q <= port_ctrl_q[`LTPM_PORT_PEAK_BIT] & mon_ctrl_q[`LTPM_MON_EN_BIT];
      port_rms_en_q  <= port_ctrl_q[`LTPM_PORT_RMS_BIT] & mon_ctrl_q[`LTPM_MON_EN_BIT];
      port_thr_en_q  <= port_ctrl_q[`LTPM_PORT_THR_BIT] & mon_ctrl_q[`LTPM_MON_EN_BIT];
    end
  end

  // absolute value of a signed sample, scaled to the magnitude width
  function automatic logic [MAG_W-1:0] abs_mag(input logic [11:0] s);
    logic [11:0] a;
    a = s[11] ? (~s + 12'h001) : s;
    return {a, 1'b0};
  endfunction

  // ==========================================================
  // per-channel flag and pin logic
  // ==========================================================
  localparam int OVR_DEPTH = `LTPM_OVR_LAT - 2;
  localparam int FM_DEPTH  = `LTPM_FM_SLOW_LAT - 1;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      logic [OVR_DEPTH-1:0] ovr_line_q;
      logic [2:0]           fm_line_q [FM_DEPTH];
      logic [MAG_W-1:0]     mag_q;
      logic [DWL_W-1:0]     dwell_q;
      ltpm_flags_t          raw;
      ltpm_flags_t          flag_q;
      ltpm_flags_t          hold_q;
      logic [3:0]           pins_d;

      // overrange delay line ahead of the flag flop
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ovr_line_q <= '0;
        end else begin
          ovr_line_q <= {ovr_line_q[OVR_DEPTH-2:0], chan_in[ch].ovr};
        end
      end

      // fast magnitude delay line for the slow pin modes
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          for (int i = 0; i < FM_DEPTH; i++) fm_line_q[i] <= 3'h0;
        end else begin
          fm_line_q[0] <= chan_in[ch].fast_mag;
          for (int i = 1; i < FM_DEPTH; i++) fm_line_q[i] <= fm_line_q[i-1];
        end
      end

      // output magnitude register
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          mag_q <= '0;
        end else begin
          mag_q <= abs_mag(chan_in[ch].sample);
        end
      end

      // dwell counter runs while below the fine low level
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          dwell_q <= '0;
        end else if (mag_q >= fine_low_trip_level_q) begin
          dwell_q <= '0;
        end else if (dwell_q != gain_raise_dwell_count_q) begin
          dwell_q <= dwell_q + DWL_W'(1);
        end
      end

      // instantaneous comparisons
      always_comb begin
        raw.ovr              = ovr_line_q[OVR_DEPTH-1];
        raw.coarse_high_flag = chan_in[ch].fast_mag > coarse_trip_level_q;
        raw.gain_lower_flag  = chan_in[ch].fast_mag > coarse_trip_level_q;
        raw.fine_high_flag   = mag_q > fine_high_trip_level_q;
        raw.fine_low_flag    = mag_q < fine_low_trip_level_q;
        raw.gain_raise_flag  = (mag_q < fine_low_trip_level_q) &&
                               (dwell_q == gain_raise_dwell_count_q);
      end

      // stretch each flag to at least two clocks
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          flag_q <= '0;
          hold_q <= '0;
        end else begin
          flag_q <= raw | hold_q;
          hold_q <= raw & ~flag_q;
        end
      end

      // pin routing by fast indicator mode
      always_comb begin
        pins_d = 4'h0;
        unique case (fd_mode)
          LTPM_FD_FM4:     pins_d = {1'b0, chan_in[ch].fast_mag};
          LTPM_FD_FM3_OR:  pins_d = {fm_line_q[FM_DEPTH-1], flag_q.ovr};
          LTPM_FD_FM2_OR:  pins_d = {fm_line_q[FM_DEPTH-1][2:1], flag_q.ovr,
                                     flag_q.fine_low_flag};
          LTPM_FD_FM2_CUT: pins_d = {fm_line_q[FM_DEPTH-1][2:1], flag_q.coarse_high_flag,
                                     flag_q.fine_low_flag};
          LTPM_FD_FLAGS:   pins_d = {flag_q.ovr, flag_q.coarse_high_flag,
                                     flag_q.fine_high_flag, flag_q.fine_low_flag};
          LTPM_FD_GAIN:    pins_d = {flag_q.ovr, flag_q.fine_high_flag,
                                     flag_q.gain_raise_flag, flag_q.gain_lower_flag};
          LTPM_FD_RSV6:    pins_d = 4'h0;
          LTPM_FD_RSV7:    pins_d = 4'h0;
        endcase
      end

      // pin register, low while indicators are disabled
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          fast_indicator_pins[ch] <= 4'h0;
        end else begin
          fast_indicator_pins[ch] <= fd_enable ? pins_d : 4'h0;
        end
      end

      // peak detector feeding this channel's result
      ltpm_peak #(
        .MAG_W (MAG_W),
        .PER_W (PER_W),
        .RES_W (RES_W)
      ) u_peak (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .active   (peak_active),
        .period   (measure_period_length_q),
        .mag      (mag_q),
        .result_q (measure_result_value[ch])
      );
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hw/ltpm_note_unused.sv */
// spare source file, holds no logic

/* File: testbench/ltpm_monitor_chk.sv */
// port checker for the level threshold and peak monitor
`timescale 1ns/1ps
`default_nettype none

module ltpm_monitor_chk
  import ltpm_pkg::*;
#(
  parameter int NCH = 2
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // converter channels
  input  wire ltpm_chan_in_t        chan_in [NCH],
  // register access
  input  wire logic [12:0]          reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_rdata_q,
  input  wire logic                 reg_rvalid_q,
  // indicator pins
  input  wire logic [NCH-1:0][3:0]  fast_indicator_pins
);
  // ==========================================
  // shadow fields and quiet time since a write
  logic [7:0]  fd_q;
  logic [2:0]  crs_q;
  logic [12:0] lo_q;
  logic [4:0]  quiet_q;
  logic [12:0] mag;
  logic        calm;

  // shadows follow writes; pins trusted only after a long quiet spell
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fd_q <= 8'h00;
      crs_q <= 3'h0;
      lo_q <= 13'h0000;
      quiet_q <= 5'h00;
    end else if (reg_wr) begin
      quiet_q <= 5'h00;
      if (reg_addr == 13'h104) fd_q <= reg_wdata;
      if (reg_addr == 13'h105) crs_q <= reg_wdata[2:0];
      if (reg_addr == 13'h108) lo_q[7:0] <= reg_wdata;
      if (reg_addr == 13'h109) lo_q[12:8] <= reg_wdata[4:0];
    end else begin
      quiet_q <= quiet_q + {4'h0, quiet_q != 5'h1f};
    end
  end

  // channel a magnitude, doubled to 13 bits
  assign mag = {chan_in[0].sample[11] ? 12'h000 - chan_in[0].sample : chan_in[0].sample, 1'b0};
  assign calm = (quiet_q == 5'h1f) && (fd_q == 8'h09);

  // ==========================================
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence read_req;
    reg_rd && !reg_wr;
  endsequence
  sequence fine_high_rise;
    $rose(fast_indicator_pins[0][1]) ##0 (calm && !reg_wr);
  endsequence

  a_read_answers: assert property (read_req |=> reg_rvalid_q)
    else $error("read got no answer");
  a_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid_q)
    else $error("answer without read");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  a_ovr_latency: assert property (calm && $past(chan_in[0].ovr, 12)
    |-> fast_indicator_pins[0][3])
    else $error("overrange pin late");
  a_ovr_quiet: assert property (calm && !$past(chan_in[0].ovr, 12)
    && !$past(chan_in[0].ovr, 13) |-> !fast_indicator_pins[0][3])
    else $error("overrange pin early");
  a_coarse_trip: assert property (calm && ($past(chan_in[0].fast_mag, 2) > crs_q)
    |-> fast_indicator_pins[0][2])
    else $error("coarse pin late");
  a_coarse_clears: assert property (calm && ($past(chan_in[0].fast_mag, 2) <= crs_q)
    && ($past(chan_in[0].fast_mag, 3) <= crs_q) |-> !fast_indicator_pins[0][2])
    else $error("coarse pin stuck");
  a_fine_low: assert property (calm && ($past(mag, 3) < lo_q)
    |-> fast_indicator_pins[0][0])
    else $error("fine low pin missing");
  a_fine_hold: assert property (fine_high_rise |=> fast_indicator_pins[0][1])
    else $error("fine high pin too short");
endmodule

`default_nettype wire

/* File: testbench/ltpm_conv_model.sv */
// converter front end feeding both channels of the level monitor
`timescale 1ns/1ps
`default_nettype none

module ltpm_conv_model
  import ltpm_pkg::*;
(
  // levels commanded by the bench
  input  wire logic [11:0]   smp_a,
  input  wire logic [11:0]   smp_b,
  input  wire logic [2:0]    fm,
  input  wire logic          ovr,
  // converter outputs
  output wire ltpm_chan_in_t chan_in [2]
);
  // fast path level and overrange shared, samples per channel
  assign chan_in[0] = '{sample: smp_a, fast_mag: fm, ovr: ovr};
  assign chan_in[1] = '{sample: smp_b, fast_mag: fm, ovr: ovr};
endmodule

`default_nettype wire

/* File: testbench/ltpm_monitor_tb.sv */
// self-checking bench for the level threshold and peak monitor
`timescale 1ns/1ps
`default_nettype none

module ltpm_monitor_tb
  import ltpm_pkg::*;
();
  // ==========================================
  // signals
  logic              sys_clk;
  logic              sys_rst;
  logic [12:0]       reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata_q;
  logic              reg_rvalid_q;
  logic [1:0][3:0]   pins;
  logic [2:0]        pen;
  logic [11:0]       smp_a;
  logic [11:0]       smp_b;
  logic [2:0]        fm;
  logic              ovr;
  wire ltpm_chan_in_t chan_in [2];
  int                n_errors;
  int                cmp_count;
  logic [11:0]       s_tab [6] = '{12'h500, 12'hb00, 12'h080, 12'h07f, 12'h400, 12'h401};
  logic [3:0]        e_tab [6] = '{4'h2, 4'h2, 4'h0, 4'h1, 4'h0, 4'h2};
  logic [3:0]        m_tab [8] = '{4'h6, 4'hc, 4'hd, 4'hf, 4'h5, 4'h3, 4'h0, 4'h0};

  ltpm_conv_model conv_u (.smp_a(smp_a), .smp_b(smp_b), .fm(fm), .ovr(ovr), .chan_in(chan_in));

  ltpm_monitor dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chan_in(chan_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .fast_indicator_pins(pins),
    .port_peak_en_q(pen[0]), .port_rms_en_q(pen[1]), .port_thr_en_q(pen[2]));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // read strobe for one edge, answer expected one edge later
  task automatic rc(input logic [12:0] a, input logic [7:0] e);
    int k;
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    k = 0;
    while (reg_rvalid_q !== 1'b1 && k < 4) begin
      @(negedge sys_clk);
      k++;
    end
    chk(24'(k), 24'h0);
    chk(24'(reg_rdata_q), 24'(e));
  endtask

  task automatic rv(input logic [12:0] a, input logic [19:0] e);
    rc(a, e[7:0]);
    rc(a + 13'h1, e[15:8]);
    rc(a + 13'h2, {4'h0, e[19:16]});
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end

  // ==========================================
  // tests
  initial begin
    n_errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    smp_a = 12'h000;
    smp_b = 12'h000;
    fm = 3'h0;
    ovr = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    // reset values, read-only and unmapped places
    rc(13'h10a, 8'h01);
    rc(13'h113, 8'h80);
    wr(13'h116, 8'h5a);
    rc(13'h116, 8'h00);
    rc(13'h1ff, 8'h00);
    wr(13'h115, 8'hc3);
    rc(13'h115, 8'hc3);
    wr(13'h115, 8'h00);
    $display("test registers done");
    // flags in mode 100, every coarse code
    wr(13'h106, 8'h00);
    wr(13'h107, 8'h08);
    wr(13'h108, 8'h00);
    wr(13'h109, 8'h01);
    wr(13'h104, 8'h09);
    for (int c = 0; c < 8; c++) begin
      wr(13'h105, 8'(c));
      fm = 3'(c);
      cyc(4);
      chk(24'(pins[0][2]), 24'h0);
      if (c < 7) begin
        fm = 3'(c + 1);
        cyc(1);
        fm = 3'(c);
        chk(24'(pins[0][2]), 24'h0);
        cyc(1);
        chk(24'(pins[0][2]), 24'h1);
        cyc(1);
        chk(24'(pins[0][2]), 24'h1);
        cyc(1);
        chk(24'(pins[0][2]), 24'h0);
      end
    end
    wr(13'h105, 8'h03);
    fm = 3'h0;
    cyc(34);
    ovr = 1'b1;
    cyc(1);
    ovr = 1'b0;
    cyc(10);
    chk(24'(pins[0]), 24'h1);
    cyc(1);
    chk(24'(pins[0]), 24'h9);
    cyc(1);
    chk(24'(pins[0]), 24'h9);
    cyc(1);
    chk(24'(pins[0]), 24'h1);
    fm = 3'h5;
    cyc(1);
    fm = 3'h0;
    cyc(6);
    for (int i = 0; i < 6; i++) begin
      smp_a = s_tab[i];
      cyc(6);
      chk(24'(pins[0]), 24'(e_tab[i]));
    end
    chk(24'(pins[1]), 24'h1);
    $display("test flags done");
    // pin routing for every mode, then disabled
    smp_a = 12'h000;
    fm = 3'h6;
    for (int m = 0; m < 8; m++) begin
      wr(13'h104, 8'((m << 1) | 1));
      cyc(10);
      chk(24'(pins), 24'({m_tab[m], m_tab[m]}));
    end
    wr(13'h104, 8'h08);
    cyc(10);
    chk(24'(pins), 24'h0);
    wr(13'h104, 8'h03);
    fm = 3'h0;
    cyc(10);
    fm = 3'h6;
    cyc(5);
    chk(24'(pins[0]), 24'h0);
    cyc(1);
    chk(24'(pins[0]), 24'hc);
    $display("test routing done");
    // gain steps with a dwell of 20 clocks
    wr(13'h104, 8'h0b);
    wr(13'h10a, 8'h14);
    fm = 3'h0;
    smp_a = 12'h200;
    cyc(10);
    chk(24'(pins[0]), 24'h0);
    smp_a = 12'h000;
    cyc(10);
    chk(24'(pins[0][1]), 24'h0);
    cyc(30);
    chk(24'(pins[0][1]), 24'h1);
    smp_a = 12'h200;
    cyc(8);
    chk(24'(pins[0][1]), 24'h0);
    smp_a = 12'h000;
    cyc(10);
    chk(24'(pins[0][1]), 24'h0);
    fm = 3'h5;
    cyc(4);
    chk(24'(pins[0][0]), 24'h1);
    fm = 3'h0;
    cyc(6);
    chk(24'(pins[0][0]), 24'h0);
    $display("test gain done");
    // peak over 128 samples, period written first, one mode for both
    smp_a = 12'h123;
    smp_b = 12'hf00;
    wr(13'h113, 8'h80);
    wr(13'h112, 8'h03);
    cyc(300);
    rv(13'h116, 20'h00246);
    rv(13'h119, 20'h00200);
    chk(24'(pen), 24'h0);
    wr(13'h111, 8'h07);
    wr(13'h112, 8'h01);
    smp_a = 12'h010;
    smp_b = 12'h7ff;
    cyc(400);
    rv(13'h116, 20'h00020);
    rv(13'h119, 20'h00ffe);
    chk(24'(pen), 24'h7);
    $display("test peak done");
    complete_run();
  end
endmodule

bind ltpm_monitor ltpm_monitor_chk #(.NCH(NCH)) chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .chan_in(chan_in), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .fast_indicator_pins(fast_indicator_pins));

`default_nettype wire
